// ===== logic/iwd_counter.sv
/*
 * Down-counter of the watchdog, one step per machine cycle.
 * Assumes the tick comes from the same clock as clk.
 */
`timescale 1ns/1ps
module iwd_counter
    import iwd_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 reinit,
    input  wire logic                 tick,
    output logic [IWD_CNT_W-1:0]      count,
    output logic                      underflow
);
    // reload on reset or power-down, else count down and wrap
    always_ff @(posedge clk)
    begin
        if (!reset_n || reinit)
            count <= IWD_CNT_INIT;           // see R1 see R12
        else if (tick)
            count <= count - 16'h0001;       // see R2 wraps to ffff
    end

    // underflow is the tick seen while at zero
    assign underflow = tick && (count == IWD_CNT_ZERO) && !reinit;   // see R3
endmodule

// ===== logic/iwd_pkg.sv
/*
 * Shared constants for the instruction clock watchdog.
 * Assumes one clock domain; control inputs arrive from on-chip logic.
 */
// Notes on behaviour
// R1: counter loads all ones, decrements per instruction clock
// R2: one decrement per machine cycle exactly
// R3: underflow from zero sets first flag
// R4: second underflow unserviced sets second flag, reset low
// R5: enable flag one keeps reset function active
// R6: disable then service clears enable flag
// R7: enable forced to one on reset, back-up
// R8: service with first flag set clears it, skips
// R9: service with first flag clear does not skip
// R10: skip works even with watchdog disabled
// R11: disable alone does not stop the watchdog
// R12: power-down entry reinitialises first flag and counter
// R13: watchdog enabled again after power-down return
// R14: program services within 65534 machine cycles
// R15: program services just before power-down
// R16: program disables after every power-down return
// R17: reset only if first flag and enable set
// R18: disable pending only for the very next instruction
package iwd_pkg;
    localparam int          IWD_CNT_W    = 16;
    localparam logic [15:0] IWD_CNT_INIT = 16'hffff;
    localparam logic [15:0] IWD_CNT_ZERO = 16'h0000;
    localparam int          IWD_SERVICE_MAX = 65534;
endpackage

// ===== logic/iwd_watchdog.sv
/*
 * Instruction clock watchdog: counter, enable flag, two underflow flags,
 * service/disable instruction handling and system reset output.
 * Assumes the instruction sequencer gives one-cycle pulses on clk.
 */
`timescale 1ns/1ps
module iwd_watchdog
    import iwd_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic instr_tick,
    input  wire logic wdog_service_instr,
    input  wire logic wdog_disable_instr,
    input  wire logic ram_backup_entry,
    input  wire logic power_down_entry,
    output logic      skip_next_r,
    output logic      wdog_enable_flag_r,
    output logic      first_underflow_flag_r,
    output logic      second_underflow_flag_r,
    output logic      sys_reset_n_r
);
    logic [IWD_CNT_W-1:0] wdog_down_counter;
    logic                 underflow;
    logic                 disable_pending_r;
    logic                 fire;
    logic [IWD_CNT_W-1:0] ticks_since_uf_r;

    iwd_counter u_cnt (
        .clk       (clk),
        .reset_n   (reset_n),
        .reinit    (power_down_entry),
        .tick      (instr_tick),
        .count     (wdog_down_counter),
        .underflow (underflow)
    );

    // second underflow only counts when armed and enabled
    assign fire = underflow && first_underflow_flag_r && wdog_enable_flag_r;  // see R4 see R17

    // disable is remembered only until the next instruction
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            disable_pending_r <= 1'b0;
        else if (instr_tick)
            disable_pending_r <= wdog_disable_instr;  // see R18 see R11
    end

    // enable flag; reset and back-up win over disable
    always_ff @(posedge clk)
    begin
        if (!reset_n || ram_backup_entry || power_down_entry)
            wdog_enable_flag_r <= 1'b1;               // see R7 see R13 see R5
        else if (instr_tick && wdog_service_instr && disable_pending_r)
            wdog_enable_flag_r <= 1'b0;               // see R6
    end

    // first flag: underflow set wins over a service clear
    always_ff @(posedge clk)
    begin
        if (!reset_n || power_down_entry)
            first_underflow_flag_r <= 1'b0;           // see R12
        else if (underflow)
            first_underflow_flag_r <= 1'b1;           // see R3
        else if (instr_tick && wdog_service_instr)
            first_underflow_flag_r <= 1'b0;           // see R8
    end

    // skip decided from the flag before the clear, regardless of enable
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            skip_next_r <= 1'b0;
        else if (instr_tick)
            skip_next_r <= wdog_service_instr && first_underflow_flag_r;  // see R8 see R9 see R10
    end

    // second flag and reset pin; held until system reset clears them
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            second_underflow_flag_r <= 1'b0;
            sys_reset_n_r           <= 1'b1;
        end
        else if (fire)
        begin
            second_underflow_flag_r <= 1'b1;          // see R4
            sys_reset_n_r           <= 1'b0;          // see R4
        end
    end

    property p_fire_resets;
        @(posedge clk) disable iff (!reset_n)
        fire |=> !sys_reset_n_r && second_underflow_flag_r;
    endproperty
    a_fire_resets: assert property (p_fire_resets) else $error("no reset on fire"); // see R4

    property p_no_reset_disabled;
        @(posedge clk) disable iff (!reset_n)
        $fell(sys_reset_n_r) |-> $past(wdog_enable_flag_r) && $past(first_underflow_flag_r);
    endproperty
    a_no_reset_disabled: assert property (p_no_reset_disabled) else $error("bad reset"); // see R17

    property p_uf_sets_first;
        @(posedge clk) disable iff (!reset_n)
        underflow |=> first_underflow_flag_r;
    endproperty
    a_uf_sets_first: assert property (p_uf_sets_first) else $error("flag not set"); // see R3

    property p_skip;
        @(posedge clk) disable iff (!reset_n)
        instr_tick |=> skip_next_r == $past(wdog_service_instr && first_underflow_flag_r);
    endproperty
    a_skip: assert property (p_skip) else $error("skip wrong"); // see R8

    // checker-only tick count since the last underflow or reload
    always_ff @(posedge clk)
    begin
        if (!reset_n || power_down_entry || underflow)
            ticks_since_uf_r <= 16'h0000;
        else if (instr_tick)
            ticks_since_uf_r <= ticks_since_uf_r + 16'h0001;
    end

    // pending disable spans idle cycles, so it is tracked, not sequenced
    property p_disable_pair;
        @(posedge clk) disable iff (!reset_n)
        instr_tick && wdog_service_instr && disable_pending_r
        && !ram_backup_entry && !power_down_entry |=> !wdog_enable_flag_r;
    endproperty
    a_disable_pair: assert property (p_disable_pair) else $error("not disabled"); // see R6

    property p_pending_load;
        @(posedge clk) disable iff (!reset_n)
        instr_tick |=> disable_pending_r == $past(wdog_disable_instr);
    endproperty
    a_pending_load: assert property (p_pending_load) else $error("pending load"); // see R18

    property p_pending_hold;
        @(posedge clk) disable iff (!reset_n)
        !instr_tick |=> $stable(disable_pending_r);
    endproperty
    a_pending_hold: assert property (p_pending_hold) else $error("pending moved"); // see R18

    property p_disable_alone;
        @(posedge clk) disable iff (!reset_n)
        $fell(wdog_enable_flag_r) |->
        $past(instr_tick && wdog_service_instr && disable_pending_r);
    endproperty
    a_disable_alone: assert property (p_disable_alone) else $error("enable fell"); // see R11

    property p_enable_rise;
        @(posedge clk) disable iff (!reset_n)
        $rose(wdog_enable_flag_r) |-> $past(ram_backup_entry || power_down_entry);
    endproperty
    a_enable_rise: assert property (p_enable_rise) else $error("enable rose"); // see R7

    property p_enable_held;
        @(posedge clk) disable iff (!reset_n)
        !instr_tick && !ram_backup_entry && !power_down_entry |=> $stable(wdog_enable_flag_r);
    endproperty
    a_enable_held: assert property (p_enable_held) else $error("enable moved"); // see R5

    property p_pd_enable;
        @(posedge clk) disable iff (!reset_n)
        power_down_entry |=> wdog_enable_flag_r;
    endproperty
    a_pd_enable: assert property (p_pd_enable) else $error("pd not enabled"); // see R13

    property p_first_rise;
        @(posedge clk) disable iff (!reset_n)
        $rose(first_underflow_flag_r) |-> $past(underflow);
    endproperty
    a_first_rise: assert property (p_first_rise) else $error("flag rose"); // see R3

    property p_first_fall;
        @(posedge clk) disable iff (!reset_n)
        $fell(first_underflow_flag_r) |->
        $past(power_down_entry || (instr_tick && wdog_service_instr));
    endproperty
    a_first_fall: assert property (p_first_fall) else $error("flag fell"); // see R8

    property p_service_clears;
        @(posedge clk) disable iff (!reset_n)
        instr_tick && wdog_service_instr && !underflow |=> !first_underflow_flag_r;
    endproperty
    a_service_clears: assert property (p_service_clears) else $error("no clear"); // see R8

    property p_skip_rise;
        @(posedge clk) disable iff (!reset_n)
        $rose(skip_next_r) |-> $past(first_underflow_flag_r);
    endproperty
    a_skip_rise: assert property (p_skip_rise) else $error("skip no flag"); // see R9

    property p_skip_clear;
        @(posedge clk) disable iff (!reset_n)
        instr_tick && !wdog_service_instr |=> !skip_next_r;
    endproperty
    a_skip_clear: assert property (p_skip_clear) else $error("skip stuck"); // see R9

    property p_skip_hold;
        @(posedge clk) disable iff (!reset_n)
        !instr_tick |=> $stable(skip_next_r);
    endproperty
    a_skip_hold: assert property (p_skip_hold) else $error("skip moved"); // see R8

    property p_skip_disabled;
        @(posedge clk) disable iff (!reset_n)
        instr_tick && wdog_service_instr && first_underflow_flag_r
        && !wdog_enable_flag_r |=> skip_next_r;
    endproperty
    a_skip_disabled: assert property (p_skip_disabled) else $error("no skip"); // see R10

    property p_second_sticky;
        @(posedge clk) disable iff (!reset_n)
        second_underflow_flag_r |=> second_underflow_flag_r;
    endproperty
    a_second_sticky: assert property (p_second_sticky) else $error("flag dropped"); // see R4

    property p_reset_sticky;
        @(posedge clk) disable iff (!reset_n)
        !sys_reset_n_r |=> !sys_reset_n_r;
    endproperty
    a_reset_sticky: assert property (p_reset_sticky) else $error("reset dropped"); // see R4

    property p_reset_pair;
        @(posedge clk) disable iff (!reset_n)
        sys_reset_n_r != second_underflow_flag_r;
    endproperty
    a_reset_pair: assert property (p_reset_pair) else $error("reset mismatch"); // see R4

    property p_second_rise;
        @(posedge clk) disable iff (!reset_n)
        $rose(second_underflow_flag_r) |-> $past(fire);
    endproperty
    a_second_rise: assert property (p_second_rise) else $error("flag no fire"); // see R17

    property p_no_tick_no_uf;
        @(posedge clk) disable iff (!reset_n)
        !instr_tick |-> !underflow;
    endproperty
    a_no_tick_no_uf: assert property (p_no_tick_no_uf) else $error("idle underflow"); // see R2

    property p_no_uf_on_pd;
        @(posedge clk) disable iff (!reset_n)
        power_down_entry |-> !underflow;
    endproperty
    a_no_uf_on_pd: assert property (p_no_uf_on_pd) else $error("pd underflow"); // see R12

    property p_uf_at_zero;
        @(posedge clk) disable iff (!reset_n)
        underflow |-> wdog_down_counter == IWD_CNT_ZERO;
    endproperty
    a_uf_at_zero: assert property (p_uf_at_zero) else $error("early underflow"); // see R3

    property p_wrap;
        @(posedge clk) disable iff (!reset_n)
        underflow |=> wdog_down_counter == IWD_CNT_INIT;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap"); // see R1

    // underflows are a full count apart, the last tick being the one at zero
    property p_uf_spacing;
        @(posedge clk) disable iff (!reset_n)
        underflow |-> ticks_since_uf_r == 16'(IWD_SERVICE_MAX + 1);
    endproperty
    a_uf_spacing: assert property (p_uf_spacing) else $error("uf spacing"); // see R4

    property p_enable_force;
        @(posedge clk) disable iff (!reset_n)
        ram_backup_entry || power_down_entry |=> wdog_enable_flag_r;
    endproperty
    a_enable_force: assert property (p_enable_force) else $error("enable not forced"); // see R7

    property p_pd_reinit;
        @(posedge clk) disable iff (!reset_n)
        power_down_entry |=> wdog_down_counter == IWD_CNT_INIT && !first_underflow_flag_r;
    endproperty
    a_pd_reinit: assert property (p_pd_reinit) else $error("no reinit"); // see R12

    property p_count_step;
        @(posedge clk) disable iff (!reset_n)
        instr_tick && !power_down_entry |=>
        wdog_down_counter == 16'($past(wdog_down_counter) - 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step"); // see R2

    property p_hold;
        @(posedge clk) disable iff (!reset_n)
        !instr_tick && !power_down_entry |=> $stable(wdog_down_counter);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved"); // see R1
endmodule

// ===== test/instruction_clock_watchdog_tb.sv
/* self-checking bench for the watchdog, against an integer model.
   assumes a single 200 MHz clock and the sequencer model. */
`timescale 1ns/1ps
module instruction_clock_watchdog_tb;
    import iwd_pkg::*;
    logic        clk = 0, reset_n = 0, te = 0, ws = 0, wd = 0, rb = 0, pd = 0;
    logic [1:0]  junk = 0;
    logic        tk, sv, ds, skip, en, f1, f2, rst_n;
    logic [31:0] lf = 32'h212de8db;
    int          n_fail = 0, n_compared = 0, cyc = 0;
    int          m_cnt, m_f1, m_en, m_f2, m_rn, m_sk, m_pd;
    always #2.5 clk = ~clk;
    iwd_seq_model iwd_seq_model_i (.tick_en(te), .want_svc(ws), .want_dis(wd), .junk(junk),
        .instr_tick(tk), .svc(sv), .dis(ds));
    iwd_watchdog iwd_watchdog_i (.clk(clk), .reset_n(reset_n), .instr_tick(tk),
        .wdog_service_instr(sv), .wdog_disable_instr(ds), .ram_backup_entry(rb),
        .power_down_entry(pd), .skip_next_r(skip), .wdog_enable_flag_r(en),
        .first_underflow_flag_r(f1), .second_underflow_flag_r(f2), .sys_reset_n_r(rst_n));
    function logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // reference model, stepped on the same edge as the design
    always @(posedge clk)
    begin : mdl
        int uf;
        uf = tk && !pd && m_cnt == 0;
        if (!reset_n) begin m_cnt = 65535; m_f1 = 0; m_en = 1; m_f2 = 0; m_rn = 1; m_sk = 0;
            m_pd = 0; end
        else begin
            if (uf && m_f1 && m_en) begin m_f2 = 1; m_rn = 0; end
            if (pd) m_cnt = 65535; else if (tk) m_cnt = (m_cnt + 65535) % 65536;
            if (tk) begin m_sk = sv && m_f1; if (sv && m_pd) m_en = 0; m_pd = ds; end
            m_f1 = uf ? 1 : ((pd || (tk && sv)) ? 0 : m_f1);
            if (pd || rb) m_en = 1;
        end
    end
    task chk(input logic a, input int e);
        n_compared++;
        if (a !== e[0]) begin n_fail++; $display("Error %0t: output differs from model", $time); end
    endtask
    // outputs are settled by the falling edge
    always @(negedge clk)
        if (cyc > 2)
        begin
            chk(skip, m_sk);
            chk(en, m_en);
            chk(f1, m_f1);
            chk(f2, m_f2);
            chk(rst_n, m_rn);
        end
    task step(input logic t, s, d, p = 0, r = 0, input int n = 1);
        repeat (n) begin @(posedge clk); #1; te = t; ws = s; wd = d; pd = p; rb = r;
            lf = nx(lf); junk = lf[1:0]; end
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // a hung run is cut short well after the expected length
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 80000) begin n_fail++; final_report; end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        #1 reset_n = 1;
        step(1, 0, 1); step(1, 0, 0); step(1, 1, 0);
        step(1, 0, 1); step(1, 1, 0); step(0, 0, 0, 0, 1);
        step(1, 1, 0); step(0, 1, 1, 0, 0, 4);
        $display("test control done");
        step(1, 0, 1); step(1, 1, 0); step(1, 0, 0, 0, 0, 65540);
        step(1, 1, 0); step(1, 0, 0); step(0, 0, 0, 1); step(1, 0, 0, 0, 0, 3);
        $display("test underflow done");
        repeat (3000) begin lf = nx(lf);
            step(lf[0], lf[1] & lf[2], lf[3] & lf[4], lf[9:5] == 0, lf[14:10] == 0); end
        step(0, 0, 0, 0, 0, 3);
        $display("test random done");
        final_report;
    end
endmodule

// ===== test/iwd_seq_model.sv
/* instruction sequencer model driving the watchdog's instruction inputs.
   assumes the bench moves its wishes just after the clk rise. */
`timescale 1ns/1ps
module iwd_seq_model (
    input  wire logic       tick_en,
    input  wire logic       want_svc,
    input  wire logic       want_dis,
    input  wire logic [1:0] junk,
    output logic            instr_tick,
    output logic            svc,
    output logic            dis
);
    // opcodes mean nothing off a tick, so show garbage there
    always_comb
    begin
        instr_tick = tick_en;
        svc        = tick_en ? want_svc : junk[0];
        dis        = tick_en ? want_dis : junk[1];
    end
endmodule
